// ===== compare_pwm_output_stage_bench.sv
// testbench: registers, pin actions, flags, protect and reset
module compare_pwm_output_stage_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import cpwm_pkg::*;
  localparam logic [15:0] CC = CPWM_IDX_COMPARE_CONTROL;
  localparam logic [15:0] ACT = CPWM_IDX_PIN_ACTIONS;
  localparam logic [15:0] DB = CPWM_IDX_DEADBAND_CONTROL;
  localparam logic [15:0] ST = CPWM_IDX_MATCH_STATUS;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [2:0] phase, cm, match_flag, bvec;
  logic tu, fault, mask_n, prot_n, vdir, sv_en;
  logic [5:0] pin, oe;
  logic [15:0] rnd, v, w;
  logic [15:0] acts [4] = '{16'h0333, 16'h0CCC, 16'h0666, 16'h0999};
  int err_total = 0;
  int total_checks = 0;
  int f, r, ovl;

  cpwm_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .phase_wave_in(phase), .compare_match(cm), .timer_underflow(tu),
    .timer_period_match(1'b0), .power_drive_protect_n(prot_n),
    .protect_mask_n(mask_n), .modulated_out_pin(pin),
    .modulated_out_oe(oe), .match_flag(match_flag),
    .vector_rotation_dir(vdir), .basic_vector_bits(bvec),
    .space_vector_en(sv_en));
  cpwm_gate_drv drv (.pin(pin), .oe(oe), .fault_cmd(fault),
    .fault_n(prot_n));

  // 4 ns clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // true and complement equal with dead-band off
  function automatic logic [5:0] exp_pins(input logic [15:0] a,
      input logic [2:0] ph);
    logic [5:0] r;
    for (int i = 0; i < 6; i++) begin
      case (a[2*i +: 2])
        2'h0: r[i] = 1'b0;
        2'h1: r[i] = ~ph[i/2];
        2'h2: r[i] = ph[i/2];
        default: r[i] = 1'b1;
      endcase
    end
    return r;
  endfunction

  task automatic complete_run();
    $display("mismatches %0d checks %0d", err_total, total_checks);
    if (err_total == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // one apb transfer; an idle edge after it avoids double drives
  task automatic apb(input logic wr_en, input logic [15:0] idx,
      input logic [15:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr_en;
    paddr <= {14'h0, idx, 2'h0};
    pwdata <= {16'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      err_total++;
      complete_run();
    end
    @(posedge pclk);
  endtask

  task automatic rdchk(input logic [15:0] idx, input logic [15:0] e);
    apb(1'b0, idx, 16'h0);
    chk(rd, {16'h0, e});
  endtask

  // watchdog: a hang counts as a mismatch
  initial begin
    tick(5000);
    err_total++;
    complete_run();
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata, phase, cm} = '0;
    {tu, fault, presetn} = '0;
    // protect masked until its own test; random actions may short a leg
    mask_n = 1'b1;
    rnd = 16'h0019;
    tick(10);
    presetn <= 1'b1;
    tick(1);
    // reset values, then an unmapped index
    rdchk(CC, 16'h0);
    rdchk(ACT, 16'h0);
    rdchk(DB, 16'h0);
    chk(oe, 6'h00);
    apb(1'b1, 16'h7419, 16'h1234);
    chk(err, 1'b1);
    // reserved bits drop, all ones first
    for (int i = 0; i < 4; i++) begin
      rnd = (i == 0) ? 16'hFFFF : lfsr(rnd);
      apb(1'b1, DB, rnd);
      rdchk(DB, rnd & 16'h0FFC);
    end
    // dead-band off for the plain action checks
    apb(1'b1, DB, 16'h0000);
    // shadow is transparent while compare is off
    v = lfsr(rnd);
    apb(1'b1, ACT, v);
    rdchk(ACT, v);
    chk(vdir, v[15]);
    chk(bvec, v[14:12]);
    apb(1'b1, CC, 16'h83FF);
    rdchk(CC, 16'h8300);
    chk(oe, 6'h3F);
    // new actions wait for the underflow strobe
    w = {~v[15], 15'h0333};
    apb(1'b1, ACT, w);
    chk(vdir, v[15]);
    tu <= 1'b1;
    tick(1);
    tu <= 1'b0;
    tick(2);
    chk(vdir, w[15]);
    // every action code after a compare event
    for (int k = 0; k < 4; k++) begin
      rnd = lfsr(rnd);
      phase <= rnd[2:0];
      apb(1'b1, ACT, acts[k]);
      tu <= 1'b1;
      tick(1);
      tu <= 1'b0;
      cm <= 3'h7;
      tick(1);
      cm <= 3'h0;
      tick(3);
      chk(pin, exp_pins(acts[k], rnd[2:0]));
    end
    // flags stick, clear by ones, set one cycle late
    rdchk(ST, 16'h7);
    apb(1'b1, ST, 16'h7);
    chk(match_flag, 3'h0);
    cm <= 3'h2;
    tick(1);
    cm <= 3'h0;
    tick(1);
    chk(match_flag, 3'h0);
    tick(1);
    chk(match_flag, 3'h2);
    // unit 1 dead-band: period 2, divide by 2, all pins active high
    apb(1'b1, DB, 16'h0224);
    apb(1'b1, ACT, 16'h0AAA);
    tu <= 1'b1;
    tick(1);
    tu <= 1'b0;
    phase <= 3'h0;
    tick(12);
    chk(pin[1:0], 2'h2);
    f = -1;
    r = -1;
    ovl = 0;
    phase <= 3'h1;
    for (int j = 0; j < 16; j++) begin
      tick(1);
      if (pin[1] == 1'b0 && f < 0) f = j;
      if (pin[0] == 1'b1 && r < 0) r = j;
      if (pin[0] && pin[1]) ovl++;
    end
    chk(r - f, 32'd4);
    chk(ovl, 0);
    // a masked protect leaves the pins driven
    mask_n <= 1'b1;
    fault <= 1'b1;
    tick(8);
    chk(oe, 6'h3F);
    mask_n <= 1'b0;
    tick(8);
    chk(oe, 6'h00);
    rdchk(CC, 16'h8100);
    fault <= 1'b0;
    // second reset in mid-run
    presetn <= 1'b0;
    tick(2);
    chk(oe, 6'h00);
    presetn <= 1'b1;
    tick(1);
    rdchk(ACT, 16'h0);
    complete_run();
  end
endmodule // compare_pwm_output_stage_bench

// ===== cpwm_deadband.sv
// one dead-band unit: prescaler, 4-bit down-counter, edge separation
module cpwm_deadband (
  input wire logic pclk,
  input wire logic presetn,
  input wire cpwm_pkg::cpwm_db_cfg_t cfg,
  input wire logic phase_wave_in,
  output cpwm_pkg::cpwm_pair_t pair
);
  import cpwm_pkg::*;

  typedef struct packed {
    logic phase_seen;
    logic [4:0] pre_cnt;
    logic [3:0] db_cnt;
    cpwm_pair_t out;
  } cpwm_db_state_t;

  cpwm_db_state_t state_reg, state_next;
  logic [4:0] pre_limit;

  // divisor minus one from the prescale code, codes above 100 give 32
  always_comb begin
    case (cfg.prescale)
      3'h0: pre_limit = 5'h00;
      3'h1: pre_limit = 5'h01;
      3'h2: pre_limit = 5'h03;
      3'h3: pre_limit = 5'h07;
      3'h4: pre_limit = 5'h0F;
      default: pre_limit = 5'h1F;
    endcase
  end

  // delayed turn-on edges
  // turn-off passes at once, turn-on waits p*m clocks
  always_comb begin
    state_next = state_reg;
    state_next.phase_seen = phase_wave_in;
    if (!cfg.enable) begin
      // copies of the phase when disabled
      state_next.out.true_out = phase_wave_in;
      state_next.out.comp_out = phase_wave_in;
      state_next.db_cnt = 4'h0;
      state_next.pre_cnt = 5'h00;
    end else if (phase_wave_in != state_reg.phase_seen) begin
      // no pair overlap
      // both sides off first unless the period is zero, so the pair can never overlap
      state_next.out.true_out = 1'b0;
      state_next.out.comp_out = 1'b0;
      state_next.db_cnt = cfg.period;
      state_next.pre_cnt = 5'h00;
      if (cfg.period == 4'h0) begin
        state_next.out.true_out = phase_wave_in;
        state_next.out.comp_out = !phase_wave_in;
      end
    end else if (state_reg.db_cnt != 4'h0) begin
      if (state_reg.pre_cnt >= pre_limit) begin
        state_next.pre_cnt = 5'h00;
        state_next.db_cnt = state_reg.db_cnt - 4'h1;
        if (state_reg.db_cnt == 4'h1) begin
          state_next.out.true_out = state_reg.phase_seen;
          state_next.out.comp_out = !state_reg.phase_seen;
        end
      end else begin
        state_next.pre_cnt = state_reg.pre_cnt + 5'h01;
      end
    end else begin
      // steady: hold complementary levels, no return to idle at period end
      state_next.out.true_out = phase_wave_in;
      state_next.out.comp_out = !phase_wave_in;
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign pair = state_reg.out;
endmodule // cpwm_deadband

// ===== cpwm_gate_drv.sv
// gate driver model: pulled-up fault line back to the protect pin
module cpwm_gate_drv (
  input wire logic [5:0] pin,
  input wire logic [5:0] oe,
  input wire logic fault_cmd,
  output logic fault_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic shoot;
  // both switches of one leg on trips desaturation at once
  assign shoot = oe[0] && |(pin[4:0] & pin[5:1] & 5'h15);
  // open-drain fault line, reads high when released
  assign fault_n = !(fault_cmd || shoot);
endmodule // cpwm_gate_drv

// ===== cpwm_pkg.sv
// package: register map, field layout and types of the compare pwm stage
package cpwm_pkg;
  // register indices (printed offsets are not multiples of four)
  localparam logic [15:0] CPWM_IDX_COMPARE_CONTROL = 16'h7411;
  localparam logic [15:0] CPWM_IDX_PIN_ACTIONS = 16'h7413;
  localparam logic [15:0] CPWM_IDX_DEADBAND_CONTROL = 16'h7415;
  localparam logic [15:0] CPWM_IDX_MATCH_STATUS = 16'h7417;
  // compare_control fields
  localparam int CPWM_CC_ENABLE_BIT = 15;
  localparam int CPWM_CC_SVENABLE_BIT = 12;
  localparam int CPWM_CC_ACTLD_LSB = 10;
  localparam int CPWM_CC_OUTEN_BIT = 9;
  localparam int CPWM_CC_PIN_OUTEN_BIT = 8;
  localparam logic [15:0] CPWM_CC_MASK = 16'hFF00;
  // action reload condition codes
  localparam logic [1:0] CPWM_LD_UNDERFLOW = 2'h0;
  localparam logic [1:0] CPWM_LD_UNDER_PERIOD = 2'h1;
  localparam logic [1:0] CPWM_LD_IMMEDIATE = 2'h2;
  // pin_actions fields
  localparam int CPWM_ACT_DIR_BIT = 15;
  localparam int CPWM_ACT_VEC_LSB = 12;
  localparam int CPWM_ACT_FIELD_W = 2;
  // pin action codes
  localparam logic [1:0] CPWM_PA_FORCE_LOW = 2'h0;
  localparam logic [1:0] CPWM_PA_ACTIVE_LOW = 2'h1;
  localparam logic [1:0] CPWM_PA_ACTIVE_HIGH = 2'h2;
  localparam logic [1:0] CPWM_PA_FORCE_HIGH = 2'h3;
  // deadband_control fields
  localparam int CPWM_DB_PERIOD_LSB = 8;
  localparam int CPWM_DB_EN_LSB = 5;
  localparam int CPWM_DB_PS_LSB = 2;
  localparam logic [15:0] CPWM_DB_MASK = 16'h0FFC;
  localparam logic [2:0] CPWM_PS_MAX_CODE = 3'h5;
  localparam logic [15:0] CPWM_RESET_VALUE = 16'h0000;
  // bundle of one dead-band unit's settings
  typedef struct packed {
    logic enable;
    logic [3:0] period;
    logic [2:0] prescale;
  } cpwm_db_cfg_t;
  // phase pair produced by a dead-band unit
  typedef struct packed {
    logic true_out;
    logic comp_out;
  } cpwm_pair_t;
endpackage : cpwm_pkg

// ===== cpwm_top.sv
// compare pwm output stage: registers over apb, dead-band, output logic
// Functional notes
// - pin actions apply every cycle while compare is enabled
// - pin actions shadowed, reload on selected condition
// - bit 15 holds vector rotation direction
// - bits 14..12 hold basic vector bits
// - six 2-bit pin action fields
// - 00 low, 01 act-low, 10 act-high, 11 high
// - match flag set one cycle after match
// - reset clears registers, pins go high-z
// - bits 11..8 shared dead-band period
// - bits 7..5 enable dead-band units 3..1
// - bits 4..2 select clock prescale divisor
// - reserved dead-band bits read zero
// - true and complementary outputs per phase
// - edge separation equals prescale times period
// - pair on-times never overlap while the dead-band unit is enabled
// - outputs high-z on disable, protect, reset
// - protect and reset override register settings
// - pins from dead-band, actions, protect
// - single clock pulse width resolution
// - minimum one clock, zero gives none
module cpwm_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] phase_wave_in,
  input wire logic [2:0] compare_match,
  input wire logic timer_underflow,
  input wire logic timer_period_match,
  input wire logic power_drive_protect_n,
  input wire logic protect_mask_n,
  output logic [5:0] modulated_out_pin,
  output logic [5:0] modulated_out_oe,
  output logic [2:0] match_flag,
  output logic vector_rotation_dir,
  output logic [2:0] basic_vector_bits,
  output logic space_vector_en
);
  import cpwm_pkg::*;

  typedef struct packed {
    logic [15:0] compare_control;
    logic [15:0] actions_shadow;
    logic [15:0] actions_active;
    logic [15:0] deadband_control;
    logic [2:0] match_flag;
    logic [2:0] match_seen;
    logic [2:0] prot_sync;
    logic [5:0] pin_level;
    logic [5:0] pin_oe;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } cpwm_state_t;

  cpwm_state_t state_reg, state_next;
  cpwm_pair_t [2:0] db_pair;
  cpwm_db_cfg_t [2:0] db_cfg;
  logic [15:0] word_index;
  logic access;
  logic wr_en;
  logic cmp_on;
  logic reload_hit;
  logic protect_active;
  logic [15:0] act_now;
  logic [15:0] wdata16;

  // byte address is four times the register index
  function automatic logic [15:0] cpwm_index(input logic [31:0] addr);
    cpwm_index = addr[17:2];
  endfunction

  function automatic logic cpwm_pin(input logic [1:0] act, input logic lvl);
    case (act)
      CPWM_PA_FORCE_LOW: cpwm_pin = 1'b0;
      CPWM_PA_ACTIVE_LOW: cpwm_pin = !lvl;
      CPWM_PA_ACTIVE_HIGH: cpwm_pin = lvl;
      default: cpwm_pin = 1'b1;
    endcase
  endfunction

  // byte-lane merge for 16-bit registers
  function automatic logic [15:0] cpwm_merge(input logic [15:0] old,
      input logic [15:0] nw, input logic [1:0] strb);
    cpwm_merge = old;
    if (strb[0]) begin
      cpwm_merge[7:0] = nw[7:0];
    end
    if (strb[1]) begin
      cpwm_merge[15:8] = nw[15:8];
    end
  endfunction

  // shared period, per-unit enable, shared prescale
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_db
      assign db_cfg[gi].enable = state_reg.deadband_control[CPWM_DB_EN_LSB
          + gi];
      assign db_cfg[gi].period =
          state_reg.deadband_control[CPWM_DB_PERIOD_LSB +: 4];
      assign db_cfg[gi].prescale =
          state_reg.deadband_control[CPWM_DB_PS_LSB +: 3];
      cpwm_deadband u_db (
        .pclk(pclk),
        .presetn(presetn),
        .cfg(db_cfg[gi]),
        .phase_wave_in(phase_wave_in[gi]),
        .pair(db_pair[gi])
      );
    end
  endgenerate

  // apb decode; one wait state, pready registered the cycle after the first access edge
  assign word_index = cpwm_index(paddr);
  assign access = psel && penable && !state_reg.pready;
  assign wr_en = access && pwrite;
  assign wdata16 = pwdata[15:0];
  assign cmp_on = state_reg.compare_control[CPWM_CC_ENABLE_BIT];
  // the protect pin passes three flops; an assertion counts when the last two agree, a release when either goes high
  assign protect_active = !protect_mask_n
      && !state_reg.prot_sync[2] && !state_reg.prot_sync[1];

  // reload condition for the action shadow
  always_comb begin
    case (state_reg.compare_control[CPWM_CC_ACTLD_LSB +: 2])
      CPWM_LD_UNDERFLOW: reload_hit = timer_underflow;
      CPWM_LD_UNDER_PERIOD: reload_hit = timer_underflow
          || timer_period_match;
      CPWM_LD_IMMEDIATE: reload_hit = 1'b1;
      default: reload_hit = 1'b0;
    endcase
  end

  // with compare disabled the shadow is transparent
  assign act_now = cmp_on ? state_reg.actions_active : state_reg.actions_shadow;

  // main next-state logic
  always_comb begin
    state_next = state_reg;
    state_next.pready = access;
    state_next.pslverr = 1'b0;
    state_next.prot_sync = {state_reg.prot_sync[1:0], power_drive_protect_n};
    state_next.match_seen = compare_match;
    // register writes, reserved bits masked off
    if (wr_en) begin
      case (word_index)
        CPWM_IDX_COMPARE_CONTROL: state_next.compare_control = cpwm_merge(
            state_reg.compare_control, wdata16, pstrb[1:0]) & CPWM_CC_MASK;
        // writes land in the shadow copy
        CPWM_IDX_PIN_ACTIONS: state_next.actions_shadow = cpwm_merge(
            state_reg.actions_shadow, wdata16, pstrb[1:0]);
        CPWM_IDX_DEADBAND_CONTROL: state_next.deadband_control = cpwm_merge(
            state_reg.deadband_control, wdata16, pstrb[1:0]) & CPWM_DB_MASK;
        // writing one clears a match flag
        CPWM_IDX_MATCH_STATUS: state_next.match_flag = state_reg.match_flag
            & ~wdata16[2:0];
        default: state_next.pslverr = 1'b1;
      endcase
    end
    // shadow moves to active on reload; transparent when disabled
    if (!cmp_on || reload_hit) begin
      state_next.actions_active = state_next.actions_shadow;
    end
    // flag one cycle after match, set beats clear
    if (cmp_on) begin
      state_next.match_flag = state_next.match_flag | state_reg.match_seen;
    end
    // protect clears the output enable bit
    if (protect_active) begin
      state_next.compare_control[CPWM_CC_OUTEN_BIT] = 1'b0;
    end
    // reads
    if (access && !pwrite) begin
      case (word_index)
        CPWM_IDX_COMPARE_CONTROL: state_next.prdata = {16'h0000,
            state_reg.compare_control};
        CPWM_IDX_PIN_ACTIONS: state_next.prdata = {16'h0000,
            state_reg.actions_shadow};
        CPWM_IDX_DEADBAND_CONTROL: state_next.prdata = {16'h0000,
            state_reg.deadband_control};
        CPWM_IDX_MATCH_STATUS: state_next.prdata = {29'h00000000,
            state_reg.match_flag};
        default: begin
          state_next.prdata = 32'h00000000;
          state_next.pslverr = 1'b1;
        end
      endcase
    end
    // pins from dead-band pairs through the actions
    for (int i = 0; i < 3; i++) begin
      if (cmp_on) begin
        state_next.pin_level[2 * i] = cpwm_pin(
            act_now[4 * i +: CPWM_ACT_FIELD_W], db_pair[i].true_out);
        state_next.pin_level[2 * i + 1] = cpwm_pin(
            act_now[4 * i + 2 +: CPWM_ACT_FIELD_W], db_pair[i].comp_out);
      end
    end
    // high-z on disable or active protect
    if (protect_active
        || !state_next.compare_control[CPWM_CC_OUTEN_BIT]
        || !state_next.compare_control[CPWM_CC_PIN_OUTEN_BIT]) begin
      state_next.pin_oe = 6'h00;
    end else begin
      state_next.pin_oe = 6'h3F;
    end
  end

  // asynchronous reset clears every bit but loads the protect synchroniser with ones, pins undriven
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
      state_reg.prot_sync <= 3'h7;
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs straight from the state flops
  assign prdata = state_reg.prdata;
  assign pready = state_reg.pready;
  assign pslverr = state_reg.pslverr;
  assign modulated_out_pin = state_reg.pin_level;
  assign modulated_out_oe = state_reg.pin_oe;
  assign match_flag = state_reg.match_flag;
  // space-vector bits handed to the vector logic
  assign vector_rotation_dir = state_reg.actions_active[CPWM_ACT_DIR_BIT];
  assign basic_vector_bits = state_reg.actions_active[CPWM_ACT_VEC_LSB +: 3];
  assign space_vector_en = state_reg.compare_control[CPWM_CC_SVENABLE_BIT];
endmodule // cpwm_top

// ===== cpwm_top_asserts.sv
// checker: port-level properties of the compare pwm stage
module cpwm_top_asserts
  import cpwm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic [2:0] compare_match,
  input wire logic power_drive_protect_n,
  input wire logic protect_mask_n,
  input wire logic [5:0] modulated_out_oe,
  input wire logic [2:0] match_flag,
  input wire logic vector_rotation_dir,
  input wire logic [2:0] basic_vector_bits
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  localparam logic [31:0] DB_A = {14'h0, CPWM_IDX_DEADBAND_CONTROL, 2'h0};
  localparam logic [31:0] ST_A = {14'h0, CPWM_IDX_MATCH_STATUS, 2'h0};
  // apb setup then first access edge
  sequence access_s;
    psel && !penable ##1 psel && penable;
  endsequence
  // protect held long enough to pass the 3-flop synchroniser
  sequence prot_s;
    (!power_drive_protect_n && !protect_mask_n) [*5];
  endsequence
  AST_APB_ANSWER:
    assert property (access_s |=> pready) else $error("apb answer late");
  AST_READY_PULSE:
    assert property (pready |=> !pready) else $error("pready held");
  AST_RESET_CLEAR:
    assert property ($rose(presetn) |-> modulated_out_oe == 6'h00
      && match_flag == 3'h0 && !vector_rotation_dir
      && basic_vector_bits == 3'h0) else $error("reset state wrong");
  AST_PROTECT_HIZ:
    assert property (prot_s |=> modulated_out_oe == 6'h00)
      else $error("protect ignored");
  AST_OE_GROUP:
    assert property (modulated_out_oe == 6'h00 || modulated_out_oe == 6'h3F)
      else $error("pins enabled apart");
  AST_FLAG_CAUSE:
    assert property ((match_flag & ~$past(match_flag)) != 3'h0 |->
      (match_flag & ~$past(match_flag) & ~$past(compare_match, 2)) == 3'h0)
      else $error("flag set without match");
  AST_FLAG_STICKY:
    assert property ((~match_flag & $past(match_flag)) != 3'h0 |->
      pready && pwrite && paddr == ST_A) else $error("flag lost");
  AST_DB_RESERVED:
    assert property (pready && !pwrite && paddr == DB_A |->
      prdata[31:12] == 20'h0 && prdata[1:0] == 2'h0)
      else $error("reserved bits set");
endmodule // cpwm_top_asserts

bind cpwm_top cpwm_top_asserts u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .compare_match(compare_match),
  .power_drive_protect_n(power_drive_protect_n),
  .protect_mask_n(protect_mask_n), .modulated_out_oe(modulated_out_oe),
  .match_flag(match_flag), .vector_rotation_dir(vector_rotation_dir),
  .basic_vector_bits(basic_vector_bits));
